// file: design/rhw_pkg.sv
// ----------------------------------------------------------------
// hour, weekday and date register constants
// ----------------------------------------------------------------
package rhw_pkg;
	// register addresses on the register port
	localparam logic [7:0] ADDR_HOURS = 8'h02;
	localparam logic [7:0] ADDR_DAY_OF_WEEK_VALUE = 8'h03;
	localparam logic [7:0] ADDR_DATE  = 8'h04;

	// field positions
	localparam int HR_FMT_BIT  = 6;   // 1 = 12-hour format
	localparam int HR_PM_BIT   = 5;   // half_day_indicator in 12-hour format
	localparam int WK_BAT_BIT  = 3;   // battery_input_enable

	// reset values and writable bits
	localparam logic [7:0] HOURS_RST     = 8'h00;
	localparam logic [3:0] DAY_OF_WEEK_VALUE_RST     = 4'h1;
	localparam logic [7:0] DATE_RST      = 8'h01;
	localparam logic [7:0] HOURS_WR_MASK = 8'h7F;
	localparam logic [7:0] DATE_WR_MASK  = 8'h3F;
	localparam logic [7:0] LOW6_MASK     = 8'h3F;
	localparam logic [7:0] LOW5_MASK     = 8'h1F;

	// bcd counting limits
	localparam logic [3:0] BCD_NINE   = 4'h9;
	localparam logic [7:0] H24_LAST   = 8'h23;
	localparam logic [7:0] H12_ELEVEN = 8'h11;
	localparam logic [7:0] H12_TWELVE = 8'h12;
	localparam logic [7:0] H12_ONE    = 8'h01;
	localparam logic [7:0] H24_ZERO   = 8'h00;
	localparam logic [2:0] DOW_FIRST  = 3'h1;
	localparam logic [2:0] DOW_LAST   = 3'h7;
	localparam logic [7:0] DATE_FIRST = 8'h01;
	localparam logic [7:0] DAYS_28    = 8'h28;
	localparam logic [7:0] DAYS_29    = 8'h29;
	localparam logic [7:0] DAYS_30    = 8'h30;
	localparam logic [7:0] DAYS_31    = 8'h31;
	localparam logic [4:0] MONTH_FEB  = 5'h02;
	localparam logic [4:0] MONTH_APR  = 5'h04;
	localparam logic [4:0] MONTH_JUN  = 5'h06;
	localparam logic [4:0] MONTH_SEP  = 5'h09;
	localparam logic [4:0] MONTH_NOV  = 5'h11;

	// oscillator detection
	localparam logic [5:0] OSC_RUN_EDGES = 6'h20;
	localparam int unsigned CLK_FREQ_MHZ = 250;
	localparam int unsigned OSF_TIME_US  = 1000;
	localparam int unsigned OSF_CYCLES   = OSF_TIME_US * CLK_FREQ_MHZ;
endpackage : rhw_pkg

// file: design/rhw_osc_if.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// oscillator monitor carrier
// ----------------------------------------------------------------
interface rhw_osc_if;
	logic osc_level;    // synchronised oscillator level
	logic osc_enable;   // oscillator enable from outside
	logic running;      // oscillator detected running
	modport mon  (input osc_level, input osc_enable, output running);
	modport regs (output osc_level, output osc_enable, input running);
endinterface : rhw_osc_if

// file: design/rhw_osc_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// oscillator running detector
// ----------------------------------------------------------------
module rhw_osc_monitor import rhw_pkg::*; #(
	parameter int unsigned OSF_CYCLES_P = OSF_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	rhw_osc_if.mon    osc
);
	localparam int IW = $clog2(OSF_CYCLES_P + 1);

	logic          level_d_reg;   // previous oscillator level
	logic [5:0]    edge_cnt_reg;  // rising edges seen so far
	logic [IW-1:0] idle_cnt_reg;  // cycles since last edge
	logic          running_reg;   // running status
	logic          rise;          // oscillator rising edge

	assign rise        = osc.osc_level & ~level_d_reg;
	assign osc.running = running_reg;

	// edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_d_reg <= 1'b0;
		end else begin
			level_d_reg <= osc.osc_level;
		end
	end

	// count edges to declare running, time out to declare stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt_reg <= '0;
			idle_cnt_reg <= '0;
			running_reg  <= 1'b0;
		end else if (!osc.osc_enable) begin
			// disabled oscillator reads as stopped at once
			edge_cnt_reg <= '0;
			idle_cnt_reg <= '0;
			running_reg  <= 1'b0;
		end else if (rise) begin
			idle_cnt_reg <= '0;
			if (edge_cnt_reg != OSC_RUN_EDGES) begin
				edge_cnt_reg <= edge_cnt_reg + 6'h01;
			end
			if (edge_cnt_reg == OSC_RUN_EDGES - 6'h01) begin
				running_reg <= 1'b1;
			end
		end else if (idle_cnt_reg == IW'(OSF_CYCLES_P - 1)) begin
			// no edge for the whole timeout: start counting afresh
			edge_cnt_reg <= '0;
			running_reg  <= 1'b0;
		end else begin
			idle_cnt_reg <= idle_cnt_reg + IW'(1);
		end
	end
endmodule : rhw_osc_monitor

// file: design/rhw_regs.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// hours, weekday and date timekeeping registers
// ----------------------------------------------------------------

// Operation
// - hours 0x02, weekday 0x03, date 0x04
// - hours bit 6 selects 12 or 24
// - 12-hour bit 5 marks PM
// - 12-hour tens digit is bit 4
// - 24-hour tens digit bits 5:4, 0-2
// - hour ones digit bits 3:0, 0-9
// - unimplemented bits read as zero
// - oscillator status bit is read only
// - power loss sets sticky flag, logs stamp
// - clearing flag zeroes time-stamp registers
// - log new stamps only while flag clear
// - weekday write clears the flag unless a loss sets it in that cycle
// - weekday bit 3 enables battery input
// - day of week holds 1 to 7
// - date tens digit bits 5:4, 0-3
// - date ones digit bits 3:0, 0-9
// - midnight rollover carries into date, weekday
// - day of week wraps 7 to 1
// - date carries to month after maximum
// - status sets after 32 oscillator edges
module rhw_regs import rhw_pkg::*; #(
	parameter int unsigned OSF_CYCLES_P = OSF_CYCLES
) (
	input  wire logic       CLOCK,
	input  wire logic       RESETN,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	input  wire logic       HOUR_CARRY,
	input  wire logic [4:0] MONTH_BCD,
	input  wire logic       LEAP_YEAR,
	output logic            MONTH_CARRY,
	input  wire logic       OSC_IN,
	input  wire logic       OSC_ENABLE,
	input  wire logic       POWER_LOST,
	output logic            TS_LOAD,
	output logic            TS_CLEAR,
	output logic            BATTERY_EN
);
	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// two-digit bcd increment, ones wrap from 9 to 0 into the tens
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == BCD_NINE) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	// last date of the month in bcd
	function automatic logic [7:0] max_day(input logic [4:0] m, input logic leap);
		logic [7:0] r;
		r = DAYS_31;
		if (m == MONTH_FEB) begin
			r = leap ? DAYS_29 : DAYS_28;
		end else if (m == MONTH_APR || m == MONTH_JUN || m == MONTH_SEP ||
		             m == MONTH_NOV) begin
			r = DAYS_30;
		end
		return r;
	endfunction : max_day

	// ------------------------------------------------------------
	// reset and input synchronisers
	// ------------------------------------------------------------
	logic       rst_meta_reg;    // reset release, first stage
	logic       rst_n;           // synchronised reset
	logic       osc_meta_reg;    // oscillator pin, first stage
	logic       osc_sync_reg;    // oscillator pin, second stage
	logic       pwr_meta_reg;    // power loss pin, first stage
	logic       pwr_sync_reg;    // power loss pin, second stage
	logic       pwr_d_reg;       // power loss history for edge
	logic       pwr_event;       // power loss rising edge

	// registers and status
	logic [7:0] hours_reg;       // format, half day, tens, ones
	logic [3:0] day_of_week_value_reg;       // battery enable and day of week
	logic [7:0] date_reg;        // date tens and ones
	logic       pwr_flag_reg;    // power_loss_flag
	logic       ts_load_reg;     // time-stamp load pulse
	logic       ts_clear_reg;    // time-stamp clear pulse
	logic       month_carry_reg; // carry into month pulse
	logic [7:0] rdata_reg;       // read data holding register

	// decode and next values
	logic       wr_hours;        // write to hours_value
	logic       wr_day_of_week_value;        // write to weekday_and_status
	logic       wr_date;         // write to date_value
	logic [7:0] hours_next;      // hour after a carry
	logic       day_tick;        // midnight rollover
	logic [7:0] date_next;       // date after a day tick
	logic       date_wrap;       // date passes its maximum
	logic [2:0] dow_next;        // day of week after a day tick
	logic       osc_running;     // monitor result

	rhw_osc_if osc_bus ();

	// release reset through two flops so every flop leaves reset together
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// oscillator and power loss pins get two flops before use; OSC_ENABLE goes to the monitor unsynchronised
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			pwr_meta_reg <= 1'b0;
			pwr_sync_reg <= 1'b0;
			pwr_d_reg    <= 1'b0;
		end else begin
			osc_meta_reg <= OSC_IN;
			osc_sync_reg <= osc_meta_reg;
			pwr_meta_reg <= POWER_LOST;
			pwr_sync_reg <= pwr_meta_reg;
			pwr_d_reg    <= pwr_sync_reg;
		end
	end

	assign pwr_event = pwr_sync_reg & ~pwr_d_reg;

	// ------------------------------------------------------------
	// oscillator monitor
	// ------------------------------------------------------------
	assign osc_bus.osc_level  = osc_sync_reg;
	assign osc_bus.osc_enable = OSC_ENABLE;
	assign osc_running        = osc_bus.running;

	rhw_osc_monitor #(
		.OSF_CYCLES_P (OSF_CYCLES_P)
	) u_osc_monitor (
		.clk   (CLOCK),
		.rst_n (rst_n),
		.osc   (osc_bus.mon)
	);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign wr_hours = REG_WR && (REG_ADDR == ADDR_HOURS);
	assign wr_day_of_week_value = REG_WR && (REG_ADDR == ADDR_DAY_OF_WEEK_VALUE);
	assign wr_date  = REG_WR && (REG_ADDR == ADDR_DATE);

	// ------------------------------------------------------------
	// hour counting
	// ------------------------------------------------------------

	// next hour on a carry from the minutes; both formats kept in bcd
	always_comb begin
		hours_next = hours_reg;
		day_tick   = 1'b0;
		if (hours_reg[HR_FMT_BIT]) begin
			// 12-hour: tens is bit 4 alone, bit 5 is the half day
			if ((hours_reg & LOW5_MASK) == H12_ELEVEN) begin
				hours_next = (hours_reg & ~LOW5_MASK) | H12_TWELVE;
				hours_next[HR_PM_BIT] = ~hours_reg[HR_PM_BIT];
				day_tick = hours_reg[HR_PM_BIT];
			end else if ((hours_reg & LOW5_MASK) == H12_TWELVE) begin
				hours_next = (hours_reg & ~LOW5_MASK) | H12_ONE;
			end else begin
				hours_next = (hours_reg & ~LOW5_MASK) |
				             (bcd_inc(hours_reg & LOW5_MASK) & LOW5_MASK);
			end
		end else begin
			// 24-hour: tens in bits 5:4 runs 0 to 2
			if ((hours_reg & LOW6_MASK) == H24_LAST) begin
				hours_next = (hours_reg & ~LOW6_MASK) | H24_ZERO;
				day_tick   = 1'b1;
			end else begin
				hours_next = (hours_reg & ~LOW6_MASK) |
				             (bcd_inc(hours_reg & LOW6_MASK) & LOW6_MASK);
			end
		end
	end

	// hours register: a write beats a carry in the same cycle
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			hours_reg <= HOURS_RST;
		end else if (wr_hours) begin
			hours_reg <= REG_WDATA & HOURS_WR_MASK;
		end else if (HOUR_CARRY) begin
			hours_reg <= hours_next;
		end
	end

	// ------------------------------------------------------------
	// day of week and date counting
	// ------------------------------------------------------------

	// day of week wraps on its own, date checks the month length
	always_comb begin
		dow_next  = day_of_week_value_reg[2:0] + DOW_FIRST;
		if (day_of_week_value_reg[2:0] == DOW_LAST) begin
			dow_next = DOW_FIRST;
		end
		date_wrap = (date_reg >= max_day(MONTH_BCD, LEAP_YEAR));
		date_next = date_wrap ? DATE_FIRST : bcd_inc(date_reg);
	end

	// weekday bits: battery enable is software owned, day of week is written by software and advanced by the day tick
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			day_of_week_value_reg <= DAY_OF_WEEK_VALUE_RST;
		end else if (wr_day_of_week_value) begin
			day_of_week_value_reg <= REG_WDATA[3:0];
		end else if (HOUR_CARRY && day_tick) begin
			day_of_week_value_reg[2:0] <= dow_next;
		end
	end

	// date register
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			date_reg <= DATE_RST;
		end else if (wr_date) begin
			date_reg <= REG_WDATA & DATE_WR_MASK;
		end else if (HOUR_CARRY && day_tick) begin
			date_reg <= date_next;
		end
	end

	// month carry pulse, one cycle, to the month counter outside
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			month_carry_reg <= 1'b0;
		end else begin
			month_carry_reg <= HOUR_CARRY && day_tick && date_wrap && !wr_date;
		end
	end

	// ------------------------------------------------------------
	// power loss flag and time-stamp control
	// ------------------------------------------------------------

	// a loss that lands on a weekday write sets the flag only if it was clear:
	// with the flag already set the write clears it and the new event is lost
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			pwr_flag_reg <= 1'b0;
			ts_load_reg  <= 1'b0;
			ts_clear_reg <= 1'b0;
		end else begin
			ts_load_reg  <= 1'b0;
			ts_clear_reg <= 1'b0;
			if (pwr_event && !pwr_flag_reg) begin
				pwr_flag_reg <= 1'b1;
				ts_load_reg  <= 1'b1;
			end else if (wr_day_of_week_value) begin
				// the written bit 4 is ignored, software can only clear
				pwr_flag_reg <= 1'b0;
				ts_clear_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------

	// read data is held until the next read; unmapped reads give zero
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				ADDR_HOURS: begin
					rdata_reg <= hours_reg & HOURS_WR_MASK;
				end
				ADDR_DAY_OF_WEEK_VALUE: begin
					rdata_reg <= {2'b00, osc_running, pwr_flag_reg, day_of_week_value_reg};
				end
				ADDR_DATE: begin
					rdata_reg <= date_reg & DATE_WR_MASK;
				end
				default: begin
					rdata_reg <= 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign REG_RDATA   = rdata_reg;
	assign MONTH_CARRY = month_carry_reg;
	assign TS_LOAD     = ts_load_reg;
	assign TS_CLEAR    = ts_clear_reg;
	assign BATTERY_EN  = day_of_week_value_reg[WK_BAT_BIT];
endmodule : rhw_regs

// file: verif/rhw_regs_checker.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// register slice port checks
// ----------------------------------------------------------------
module rhw_regs_checker import rhw_pkg::*; #(
	parameter int unsigned OSF_CYCLES_P = OSF_CYCLES
) (
	input wire logic       CLOCK,
	input wire logic       RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       HOUR_CARRY,
	input wire logic [4:0] MONTH_BCD,
	input wire logic       LEAP_YEAR,
	input wire logic       MONTH_CARRY,
	input wire logic       OSC_IN,
	input wire logic       OSC_ENABLE,
	input wire logic       POWER_LOST,
	input wire logic       TS_LOAD,
	input wire logic       TS_CLEAR,
	input wire logic       BATTERY_EN
);
	logic [2:0] up_cnt; // edges since reset release
	logic       rdy;    // internal reset and pin synchronisers settled
	logic       wr_wk;  // write to the weekday register
	logic       rd_wk;  // read of the weekday register

	// waits out the two-flop release so pin samples from reset do not count
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			up_cnt <= 3'h0;
		end else if (up_cnt != 3'h7) begin
			up_cnt <= up_cnt + 3'h1;
		end
	end
	assign rdy   = (up_cnt == 3'h7);
	assign wr_wk = REG_WR && (REG_ADDR == ADDR_DAY_OF_WEEK_VALUE);
	assign rd_wk = REG_RD && (REG_ADDR == ADDR_DAY_OF_WEEK_VALUE);

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	property p_unmapped;
		REG_RD && (REG_ADDR < ADDR_HOURS || REG_ADDR > ADDR_DATE) |=> REG_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hours_top;
		REG_RD && (REG_ADDR == ADDR_HOURS) |=> !REG_RDATA[7];
	endproperty
	a_hours_top: assert property (p_hours_top) else $error("hours bit 7 set");
	property p_wk_fields;
		rd_wk && rdy |=> REG_RDATA[7:6] == 2'h0 && REG_RDATA[2:0] != 3'h0;
	endproperty
	a_wk_fields: assert property (p_wk_fields) else $error("weekday fields bad");
	property p_date_top;
		REG_RD && (REG_ADDR == ADDR_DATE) |=> REG_RDATA[7:6] == 2'h0;
	endproperty
	a_date_top: assert property (p_date_top) else $error("date top bits set");
	property p_ts_clear;
		wr_wk && rdy && (POWER_LOST == $past(POWER_LOST, 4)) |=> TS_CLEAR ##1 !TS_CLEAR;
	endproperty
	a_ts_clear: assert property (p_ts_clear) else $error("no stamp clear");
	property p_ts_load;
		TS_LOAD && rdy |-> $past(POWER_LOST, 2) && !$past(POWER_LOST, 5);
	endproperty
	a_ts_load: assert property (p_ts_load) else $error("stamp load w/o loss");
	property p_month;
		MONTH_CARRY |-> $past(HOUR_CARRY) ##1 !MONTH_CARRY;
	endproperty
	a_month: assert property (p_month) else $error("month carry w/o hour");
	property p_bat;
		wr_wk && rdy |=> BATTERY_EN == $past(REG_WDATA[WK_BAT_BIT]);
	endproperty
	a_bat: assert property (p_bat) else $error("battery enable wrong");
	property p_bat_hold;
		!wr_wk && rdy |=> $stable(BATTERY_EN);
	endproperty
	a_bat_hold: assert property (p_bat_hold) else $error("battery enable moved");
	property p_osc_off;
		rd_wk && !OSC_ENABLE && !$past(OSC_ENABLE) |=> !REG_RDATA[5];
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("status set while off");

	c_month: cover property (HOUR_CARRY ##1 MONTH_CARRY);
	c_load: cover property (TS_LOAD);
	c_clear: cover property (TS_CLEAR);
	c_osc: cover property (rd_wk ##1 REG_RDATA[5]);
endmodule : rhw_regs_checker

bind rhw_regs rhw_regs_checker #(.OSF_CYCLES_P(OSF_CYCLES_P)) u_chk (
	.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.HOUR_CARRY(HOUR_CARRY), .MONTH_BCD(MONTH_BCD), .LEAP_YEAR(LEAP_YEAR),
	.MONTH_CARRY(MONTH_CARRY), .OSC_IN(OSC_IN), .OSC_ENABLE(OSC_ENABLE),
	.POWER_LOST(POWER_LOST), .TS_LOAD(TS_LOAD), .TS_CLEAR(TS_CLEAR),
	.BATTERY_EN(BATTERY_EN));

// file: verif/rhw_osc_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// crystal stand-in driving the oscillator pin
// ----------------------------------------------------------------
module rhw_osc_src #(
	parameter int HALF = 8 // cycles per half period, much faster than a crystal
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic run,  // crystal swinging
	output logic      osc   // oscillator level
);
	int cnt; // cycles into the half period

	// a stopped crystal holds its level, so the monitor sees no edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			osc <= 1'b0;
		end else if (!run) begin
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			osc <= ~osc;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : rhw_osc_src

// file: verif/tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// register slice testbench
// ----------------------------------------------------------------
module tb import rhw_pkg::*;;
	logic       clk, rst_n, reg_wr, reg_rd, hour_carry, leap, month_carry;
	logic       osc_in, osc_en, osc_run, power_lost, ts_load, ts_clear, battery_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, n;
	logic [4:0] month;
	int         errors, total_checks;

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	rhw_regs #(.OSF_CYCLES_P(64)) DUT (
		.CLOCK(clk), .RESETN(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.HOUR_CARRY(hour_carry), .MONTH_BCD(month), .LEAP_YEAR(leap),
		.MONTH_CARRY(month_carry), .OSC_IN(osc_in), .OSC_ENABLE(osc_en),
		.POWER_LOST(power_lost), .TS_LOAD(ts_load), .TS_CLEAR(ts_clear),
		.BATTERY_EN(battery_en));
	rhw_osc_src #(.HALF(8)) u_osc (.clk(clk), .rst_n(rst_n), .run(osc_run), .osc(osc_in));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task results;
		if (errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	// one-cycle strobe; the register changes at the strobe's edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk) #1 reg_wr = 1'b0;
	endtask : wr
	// data is settled just after the edge that follows the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) #1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk) #1 reg_rd = 1'b0;
		check(reg_rdata, exp);
	endtask : rd
	task count_loads;
		n = 8'h00;
		repeat (8) begin
			@(posedge clk) #1;
			if (ts_load === 1'b1) n = n + 8'h01;
		end
	endtask : count_loads
	// load the time, advance one hour, check the carries
	task roll(input logic [7:0] h, d, input logic [2:0] w, input logic [4:0] m,
		input logic lp, input logic [7:0] eh, ed, input logic [2:0] ew, input logic ec);
		wr(ADDR_HOURS, h);
		wr(ADDR_DATE, d);
		wr(ADDR_DAY_OF_WEEK_VALUE, {5'h00, w});
		check({7'h00, battery_en}, 8'h00);
		{month, leap} = {m, lp};
		@(posedge clk) #1 hour_carry = 1'b1;
		@(posedge clk) #1 hour_carry = 1'b0;
		check({7'h00, month_carry}, {7'h00, ec});
		@(posedge clk) #1 check({7'h00, month_carry}, 8'h00);
		rd(ADDR_HOURS, eh);
		rd(ADDR_DATE, ed);
		rd(ADDR_DAY_OF_WEEK_VALUE, {5'h00, ew});
	endtask : roll

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, hour_carry, leap, osc_en, osc_run, power_lost} = 8'h00;
		{reg_addr, reg_wdata, month, errors, total_checks} = 0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_HOURS, HOURS_RST);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h01);
		rd(ADDR_DATE, DATE_RST);
		rd(8'h00, 8'h00);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h00);
		wr(ADDR_HOURS, 8'hFF);
		rd(ADDR_HOURS, 8'h7F);
		wr(ADDR_DATE, 8'hFF);
		rd(ADDR_DATE, 8'h3F);
		wr(ADDR_DAY_OF_WEEK_VALUE, 8'hFF);
		check({7'h00, battery_en}, 8'h01);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h0F);
		roll(8'h23, 8'h31, 3'd7, 5'h01, 0, 8'h00, 8'h01, 3'd1, 1);
		roll(8'h09, 8'h15, 3'd3, 5'h01, 0, 8'h10, 8'h15, 3'd3, 0);
		roll(8'h19, 8'h15, 3'd3, 5'h01, 0, 8'h20, 8'h15, 3'd3, 0);
		roll(8'h71, 8'h28, 3'd2, 5'h02, 1, 8'h52, 8'h29, 3'd3, 0);
		roll(8'h51, 8'h10, 3'd2, 5'h02, 0, 8'h72, 8'h10, 3'd2, 0);
		roll(8'h52, 8'h10, 3'd2, 5'h02, 0, 8'h41, 8'h10, 3'd2, 0);
		roll(8'h49, 8'h10, 3'd2, 5'h02, 0, 8'h50, 8'h10, 3'd2, 0);
		roll(8'h23, 8'h28, 3'd2, 5'h02, 0, 8'h00, 8'h01, 3'd3, 1);
		roll(8'h23, 8'h29, 3'd5, 5'h02, 1, 8'h00, 8'h01, 3'd6, 1);
		roll(8'h23, 8'h30, 3'd1, 5'h04, 0, 8'h00, 8'h01, 3'd2, 1);
		roll(8'h23, 8'h30, 3'd1, 5'h11, 0, 8'h00, 8'h01, 3'd2, 1);
		roll(8'h23, 8'h30, 3'd1, 5'h05, 0, 8'h00, 8'h31, 3'd2, 0);
		roll(8'h23, 8'h09, 3'd4, 5'h01, 0, 8'h00, 8'h10, 3'd5, 0);
		roll(8'h23, 8'h29, 3'd4, 5'h01, 0, 8'h00, 8'h30, 3'd5, 0);
		// power loss: sticky flag, one stamp, cleared by any weekday write
		wr(ADDR_DAY_OF_WEEK_VALUE, 8'h19);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h09);
		power_lost = 1'b1;
		count_loads();
		check(n, 8'h01);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h19);
		power_lost = 1'b0;
		count_loads();
		power_lost = 1'b1;
		count_loads();
		check(n, 8'h00);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h19);
		wr(ADDR_DAY_OF_WEEK_VALUE, 8'h1A);
		check({7'h00, ts_clear}, 8'h01);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h0A);
		power_lost = 1'b0;
		count_loads();
		power_lost = 1'b1;
		count_loads();
		check(n, 8'h01);
		wr(ADDR_DAY_OF_WEEK_VALUE, 8'h0A);
		// oscillator status: 32 edges to set, stall or disable to clear
		{osc_en, osc_run} = 2'b11;
		repeat (200) @(posedge clk);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h0A);
		repeat (400) @(posedge clk);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h2A);
		osc_run = 1'b0;
		repeat (100) @(posedge clk);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h0A);
		osc_run = 1'b1;
		repeat (600) @(posedge clk);
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h2A);
		osc_en = 1'b0;
		rd(ADDR_DAY_OF_WEEK_VALUE, 8'h0A);
		// second reset in mid-run
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_HOURS, HOURS_RST);
		check({7'h00, battery_en}, 8'h00);
		results();
	end

	// watchdog well beyond the expected run of some 1600 cycles
	initial begin
		#100000;
		errors = errors + 1;
		results();
	end
endmodule : tb
